//--- tbx_top.v
// mdio slave holding the 10base-t operations and extended control registers
// assumes mdc, mdio, tx_en, the crossover pin and the address straps are
// asynchronous pins; all other inputs come from core logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "tbx_regs.vh"

module tbx_top #(
    parameter SQE_CYCLES = `TBX_SQE_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       mdc,
    input  wire       mdio_in,
    output reg        mdio_out,
    output wire       mdio_oe_n,
    input  wire [4:0] phy_addr,
    input  wire       tx_en,
    input  wire       crossover_auto_pin,
    input  wire       polarity_reversed_det,
    input  wire       remote_jabber_det,
    input  wire       partner_link_fault,
    input  wire       speed_10,
    input  wire       full_duplex,
    input  wire       rx_activity,
    input  wire       collision_det,
    input  wire       rx_valid_data,
    input  wire       rx_idle,
    input  wire       link_signal_lost,
    input  wire       resolver_cross,
    input  wire       resolver_done,
    output reg        rx_polarity_correct,
    output reg        jabber_check_en,
    output wire       col,
    output reg        crs,
    output reg        link_pass,
    output reg        crossover_done,
    output reg        pair_cross,
    output reg        tx_pair_oe_n,
    output reg        tx100_power_down
);

    ////////////////////////////////////////////////////////////////////////////
    localparam S_PRE  = 3'h0;
    localparam S_ST   = 3'h1;
    localparam S_HDR  = 3'h2;
    localparam S_TA   = 3'h3;
    localparam S_DATA = 3'h4;

    wire [8:0] pins_sync;
    wire       mdc_s;
    wire       mdio_s;
    wire       tx_en_s;
    wire       auto_pin_s;
    wire [4:0] addr_s;

    reg        mdc_d;
    reg  [2:0] state;
    reg  [5:0] pre_cnt;
    reg  [3:0] bit_cnt;
    reg [11:0] hdr;
    reg        is_read;
    reg        is_write;
    reg        hit_ops;
    reg        hit_ext;
    reg [15:0] wr_shift;
    reg [15:0] rd_shift;
    reg        drive;
    reg [15:0] ops_reg;
    reg [15:0] ext_reg;
    reg        pol_latch;
    reg        jab_latch;
    reg        link_ok;
    reg        data_seen;
    reg        clr_latches;

    wire        mdc_rise;
    wire        mdc_fall;
    wire [11:0] next_hdr;
    wire [15:0] next_wr;
    wire [15:0] ops_view;
    wire [15:0] ext_view;
    wire        sqe_enable;
    wire        sqe_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // pins through two flops before any decode
    tbx_sync #(
        .WIDTH (9)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({phy_addr, crossover_auto_pin, tx_en, mdio_in, mdc}),
        .sync_out (pins_sync)
    );

    assign mdc_s      = pins_sync[0];
    assign mdio_s     = pins_sync[1];
    assign tx_en_s    = pins_sync[2];
    assign auto_pin_s = pins_sync[3];
    assign addr_s     = pins_sync[8:4];

    assign mdc_rise = mdc_s && !mdc_d;
    assign mdc_fall = !mdc_s && mdc_d;
    assign next_hdr = {hdr[10:0], mdio_s};
    assign next_wr  = {wr_shift[14:0], mdio_s};

    ////////////////////////////////////////////////////////////////////////////
    // read views; latched status shows the live level or any event since the clear that follows a read
    function [15:0] ops_read;
        input [15:0] stored;
        input        jab;
        input        pol;
        begin
            ops_read = stored & `TBX_OPS_RW_MASK;
            ops_read[`TBX_OPS_REM_JAB] = jab;
            ops_read[`TBX_OPS_POL_REV] = pol;
        end
    endfunction

    function [15:0] ext_read;
        input [15:0] stored;
        input        fault;
        begin
            ext_read = stored & `TBX_EXT_RW_MASK;
            ext_read[`TBX_EXT_NODE]    = 1'b0;
            ext_read[`TBX_EXT_SWMODE]  = 1'b1;
            ext_read[`TBX_EXT_RFAULT]  = fault;
            ext_read[`TBX_EXT_RO_RSVD] = 1'b0;
        end
    endfunction

    assign ops_view = ops_read(ops_reg, jab_latch | remote_jabber_det,
                               pol_latch | polarity_reversed_det);
    assign ext_view = ext_read(ext_reg, partner_link_fault);

    ////////////////////////////////////////////////////////////////////////////
    // frame decode on mdc rising edges
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mdc_d       <= 1'b0;
            state       <= S_PRE;
            pre_cnt     <= 6'h00;
            bit_cnt     <= 4'h0;
            hdr         <= 12'h000;
            is_read     <= 1'b0;
            is_write    <= 1'b0;
            hit_ops     <= 1'b0;
            hit_ext     <= 1'b0;
            wr_shift    <= 16'h0000;
            ops_reg     <= `TBX_OPS_RESET;
            ext_reg     <= `TBX_EXT_RESET;
            clr_latches <= 1'b0;
        end else begin
            mdc_d       <= mdc_s;
            clr_latches <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    S_PRE: begin
                        if (mdio_s) begin
                            if (pre_cnt != `TBX_PREAMBLE_BITS)
                                pre_cnt <= pre_cnt + 6'h01;
                        end else begin
                            if (pre_cnt == `TBX_PREAMBLE_BITS)
                                state <= S_ST;
                            pre_cnt <= 6'h00;
                        end
                    end
                    S_ST: begin
                        bit_cnt <= 4'h0;
                        state   <= mdio_s ? S_HDR : S_PRE;
                    end
                    S_HDR: begin
                        hdr     <= next_hdr;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'hb) begin
                            bit_cnt  <= 4'h0;
                            state    <= S_TA;
                            is_read  <= next_hdr[11:10] == `TBX_OP_READ;
                            is_write <= next_hdr[11:10] == `TBX_OP_WRITE;
                            hit_ops  <= next_hdr[9:5] == addr_s &&
                                        next_hdr[4:0] == `TBX_REG_TEN_OPS;
                            hit_ext  <= next_hdr[9:5] == addr_s &&
                                        next_hdr[4:0] == `TBX_REG_EXT_CTL;
                        end
                    end
                    S_TA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        // clear only after the read snapshot; an event that comes and goes between snapshot and clear is lost
                        if (bit_cnt == 4'h1 && is_read && hit_ops)
                            clr_latches <= 1'b1;
                        if (bit_cnt == 4'h1) begin
                            bit_cnt <= 4'h0;
                            state   <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        wr_shift <= next_wr;
                        bit_cnt  <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'hf) begin
                            state   <= S_PRE;
                            pre_cnt <= 6'h00;
                            // reserved bits other than ext bit 10 take whatever is written; the manager
                            // is trusted to write their defaults back
                            if (is_write && hit_ops)
                                ops_reg <= next_wr & `TBX_OPS_RW_MASK;
                            if (is_write && hit_ext)
                                ext_reg <= next_wr & `TBX_EXT_RW_MASK;
                        end
                    end
                    default: begin
                        state <= S_PRE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data goes out on mdc falling edges, zero in second turnaround bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            drive    <= 1'b0;
            mdio_out <= 1'b1;
            rd_shift <= 16'h0000;
        end else if (mdc_fall) begin
            if (state == S_TA && bit_cnt == 4'h1 && is_read && (hit_ops || hit_ext)) begin
                drive    <= 1'b1;
                mdio_out <= 1'b0;
                rd_shift <= hit_ops ? ops_view : ext_view;
            end else if (state == S_DATA && drive) begin
                mdio_out <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
            end else begin
                drive    <= 1'b0;
                mdio_out <= 1'b1;
            end
        end
    end

    assign mdio_oe_n = ~drive;

    ////////////////////////////////////////////////////////////////////////////
    // latched status: an event in the clearing cycle survives the clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pol_latch <= 1'b0;
            jab_latch <= 1'b0;
        end else begin
            pol_latch <= polarity_reversed_det | (pol_latch & ~clr_latches);
            jab_latch <= remote_jabber_det | (jab_latch & ~clr_latches);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sqe test: node only, so the sqe inhibit bit, full duplex or a speed other than 10 suppresses; the bit itself is untouched
    assign sqe_enable = ~ops_reg[`TBX_OPS_SQE_INH] & speed_10 & ~full_duplex;

    tbx_sqe #(
        .PULSE_CYCLES (SQE_CYCLES)
    ) u_sqe (
        .clk         (clk),
        .rst         (rst),
        .tx_en       (tx_en_s),
        .test_enable (sqe_enable),
        .sqe_pulse   (sqe_pulse)
    );

    assign col = collision_det | sqe_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // 10base-t link integrity; squelch inhibit demands an idle after data
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            link_ok   <= 1'b0;
            data_seen <= 1'b0;
        end else if (link_signal_lost) begin
            link_ok   <= 1'b0;
            data_seen <= 1'b0;
        end else begin
            if (rx_valid_data)
                data_seen <= 1'b1;
            if (!ops_reg[`TBX_OPS_SQL_INH] && rx_valid_data)
                link_ok <= 1'b1;
            else if (ops_reg[`TBX_OPS_SQL_INH] && data_seen && rx_idle)
                link_ok <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs, registered so they are defined from reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_polarity_correct <= 1'b0;
            jabber_check_en     <= 1'b1;
            crs                 <= 1'b0;
            link_pass           <= 1'b0;
            crossover_done      <= 1'b0;
            pair_cross          <= 1'b0;
            tx_pair_oe_n        <= 1'b0;
            tx100_power_down    <= 1'b0;
        end else begin
            // correction keeps the receive path usable either way round
            rx_polarity_correct <= polarity_reversed_det &
                                   ~ops_reg[`TBX_OPS_APOL_INH];
            jabber_check_en     <= ~ops_reg[`TBX_OPS_JAB_INH];
            crs                 <= tx_en_s | rx_activity;
            link_pass           <= ops_reg[`TBX_OPS_LINK_INH] | link_ok;
            if (ext_reg[`TBX_EXT_AUTO_EN] && auto_pin_s) begin
                // an inverted cable never lets the resolver finish
                crossover_done <= resolver_done & ~polarity_reversed_det;
                pair_cross     <= resolver_cross;
            end else begin
                crossover_done <= 1'b0;
                pair_cross     <= ~ext_reg[`TBX_EXT_AUTO_EN] &
                                  ext_reg[`TBX_EXT_SWAP_SEL];
            end
            tx_pair_oe_n     <= ext_reg[`TBX_EXT_TRISTATE];
            tx100_power_down <= ext_reg[`TBX_EXT_AUTO_PD] & speed_10;
        end
    end

endmodule

`default_nettype wire

//--- tbx_regs.vh
// constants for the 10base-t operations and extended control register pair
// assumes inclusion by the management core, its sqe helper module, the station manager model and the bench
`ifndef TBX_REGS_VH
`define TBX_REGS_VH

////////////////////////////////////////////////////////////////////////////////
`define TBX_REG_TEN_OPS       5'h12
`define TBX_REG_EXT_CTL       5'h13
`define TBX_OP_READ           2'h2
`define TBX_OP_WRITE          2'h1
`define TBX_PREAMBLE_BITS     6'h20

////////////////////////////////////////////////////////////////////////////////
`define TBX_OPS_REM_JAB       15
`define TBX_OPS_POL_REV       14
`define TBX_OPS_JAB_INH       5
`define TBX_OPS_APOL_INH      3
`define TBX_OPS_SQE_INH       2
`define TBX_OPS_LINK_INH      1
`define TBX_OPS_SQL_INH       0
`define TBX_OPS_RW_MASK       16'h3fff
`define TBX_OPS_RESET         16'h0010

`define TBX_EXT_NODE          15
`define TBX_EXT_SWMODE        14
`define TBX_EXT_RFAULT        13
`define TBX_EXT_RO_RSVD       10
`define TBX_EXT_AUTO_EN       9
`define TBX_EXT_SWAP_SEL      8
`define TBX_EXT_TRISTATE      7
`define TBX_EXT_AUTO_PD       0
`define TBX_EXT_RW_MASK       16'h1bff
`define TBX_EXT_RESET         16'h0200

////////////////////////////////////////////////////////////////////////////////
`define TBX_CLK_MHZ           200
`define TBX_SQE_TIME_NS       1000
`define TBX_SQE_CYCLES        ((`TBX_SQE_TIME_NS * `TBX_CLK_MHZ + 999) / 1000)

`endif

//--- tbx_sync.v
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no bus coherence is given
`timescale 1ns/1ps
`default_nettype none

module tbx_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

//--- tbx_sqe.v
// sqe test pulse generator: one collision pulse after each transmit end
// assumes tx_en is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "tbx_regs.vh"

module tbx_sqe #(
    parameter PULSE_CYCLES = `TBX_SQE_CYCLES
) (
    input  wire clk,
    input  wire rst,
    input  wire tx_en,
    input  wire test_enable,
    output reg  sqe_pulse
);

    reg        tx_en_d;
    reg [15:0] width_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // enable is looked at only on the falling edge of tx_en
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_d   <= 1'b0;
            width_cnt <= 16'h0000;
            sqe_pulse <= 1'b0;
        end else begin
            tx_en_d <= tx_en;
            if (tx_en_d && !tx_en && test_enable) begin
                width_cnt <= PULSE_CYCLES[15:0];
                sqe_pulse <= 1'b1;
            end else if (width_cnt > 16'h0001) begin
                width_cnt <= width_cnt - 16'h0001;
            end else begin
                width_cnt <= 16'h0000;
                sqe_pulse <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

//--- tbx_sta_model.sv
// station manager model: runs mdc and mdio frames, resolves the mdio wire
// assumes a pull-up on mdio and an active-low enable on the device side
`timescale 1ns/1ps
`default_nettype none
`include "tbx_regs.vh"
module tbx_sta_model (
    input  wire logic        mdio_out,
    input  wire logic        mdio_oe_n,
    output var  logic        mdc,
    output wire logic        mdio_in,
    output var  logic [15:0] rd_data,
    output var  logic        rd_done
);
    logic    drv_en;
    logic    drv_bit;
    realtime hp;
    // released wire floats to the pull-up level, never the last bit
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
        rd_data = 16'h0000;
        rd_done = 1'b0;
        hp = 32.0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic bit_cyc(input logic en, input logic b);
        drv_en = en;
        drv_bit = b;
        #(hp) mdc = 1'b1;
        #(hp) mdc = 1'b0;
    endtask
    // mdc stands still low between frames; half-ns offset keeps edges off clk rising edges in a frame started on one
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd);
        logic [13:0] hdr;
        hdr = {2'b01, op, pa, ra};
        #0.5;
        repeat (32) bit_cyc(1'b1, 1'b1);
        for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i]);
        if (op == `TBX_OP_WRITE) begin
            bit_cyc(1'b1, 1'b1);
            bit_cyc(1'b1, 1'b0);
            for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wd[i]);
        end else begin
            repeat (2) bit_cyc(1'b0, 1'b1);
            for (int i = 15; i >= 0; i--) begin
                drv_en = 1'b0;
                #(hp) mdc = 1'b1;
                rd_data[i] = mdio_in;
                #(hp) mdc = 1'b0;
            end
            rd_done = 1'b1;
            #1 rd_done = 1'b0;
        end
        drv_en = 1'b0;
        #(8 * hp);
    endtask
endmodule
`default_nettype wire

//--- tbx_top_props.sv
// checker: timing relations seen on the ports of tbx_top
// assumes bind into tbx_top; one clk domain with async rst
`timescale 1ns/1ps
`default_nettype none
module tbx_top_props #(
    parameter int SQE_CYCLES = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic tx_en,
    input wire logic polarity_reversed_det,
    input wire logic speed_10,
    input wire logic full_duplex,
    input wire logic rx_activity,
    input wire logic collision_det,
    input wire logic resolver_done,
    input wire logic resolver_cross,
    input wire logic rx_polarity_correct,
    input wire logic jabber_check_en,
    input wire logic col,
    input wire logic crs,
    input wire logic crossover_done,
    input wire logic pair_cross,
    input wire logic tx_pair_oe_n,
    input wire logic tx100_power_down
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    int unsigned run;
    // counts col high without a real collision; width is judged at its fall
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            run <= 0;
        end else begin
            run <= (col && !collision_det) ? run + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence sqe_end;
        $fell(col) ##0 !collision_det && !$past(collision_det);
    endsequence
    sequence fd_tx_end;
        $fell(tx_en) && full_duplex ##1 (full_duplex && !collision_det)[*8];
    endsequence
    sqe_width_a: assert property (sqe_end |-> run == SQE_CYCLES)
        else $error("sqe pulse width wrong");
    fd_no_sqe_a: assert property (fd_tx_end |-> !col)
        else $error("sqe pulse in full duplex");
    col_carry_a: assert property (collision_det |-> col)
        else $error("collision not on col");
    crs_rx_a: assert property (rx_activity |=> crs)
        else $error("crs missing on receive");
    pol_fix_a: assert property (rx_polarity_correct |-> $past(polarity_reversed_det))
        else $error("polarity fix without reversal");
    xdone_a: assert property (crossover_done |->
        $past(resolver_done && !polarity_reversed_det))
        else $error("crossover done on bad cable");
    xfollow_a: assert property (crossover_done |-> pair_cross == $past(resolver_cross))
        else $error("pair choice not from resolver");
    apd_ten_a: assert property (tx100_power_down |-> $past(speed_10))
        else $error("power down outside 10 mbit");
    rst_vals_a: assert property ($fell(rst) |->
        jabber_check_en && !tx_pair_oe_n && !tx100_power_down && mdio_oe_n)
        else $error("wrong output after reset");
    mdio_ta_a: assert property ($fell(mdio_oe_n) |-> !mdc && !mdio_out)
        else $error("turnaround drive wrong");
    mdio_hold_a: assert property (!mdio_oe_n && mdc |-> $stable(mdio_out))
        else $error("mdio changed while mdc high");
endmodule
bind tbx_top tbx_top_props #(.SQE_CYCLES(SQE_CYCLES)) i_props (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .tx_en(tx_en), .polarity_reversed_det(polarity_reversed_det), .speed_10(speed_10),
    .full_duplex(full_duplex), .rx_activity(rx_activity), .collision_det(collision_det),
    .resolver_done(resolver_done), .resolver_cross(resolver_cross),
    .rx_polarity_correct(rx_polarity_correct), .jabber_check_en(jabber_check_en),
    .col(col), .crs(crs), .crossover_done(crossover_done), .pair_cross(pair_cross),
    .tx_pair_oe_n(tx_pair_oe_n), .tx100_power_down(tx100_power_down)
);
`default_nettype wire

//--- tb_top.sv
// self-checking bench for tbx_top with a station manager model on mdio
// assumes tbx_sta_model and tbx_top_props are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tbx_regs.vh"
module tb_top;
    localparam int SQE = 10;
    logic             clk;
    logic             rst;
    logic [4:0]       phy_addr;
    logic             tx_en, xpin, pol_det, jab_det, fault, spd10, fdx, rx_act;
    logic             coll, rx_vld, rx_idle, lost, res_x, res_done;
    wire logic        mdc, mdio_in, mdio_out, mdio_oe_n, rd_done;
    wire logic        pol_ok, jab_en, col, crs, link_pass, x_done, pair_x, tp_oe_n, pd100;
    wire logic [15:0] rd_data;
    logic [15:0]      exp_q[$];
    logic [15:0]      v18, v19;
    logic [31:0]      r;
    int               err_count, cmp_count, cyc, hi;
    tbx_top #(.SQE_CYCLES(SQE)) i_dut (
        .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr), .tx_en(tx_en),
        .crossover_auto_pin(xpin), .polarity_reversed_det(pol_det),
        .remote_jabber_det(jab_det), .partner_link_fault(fault), .speed_10(spd10),
        .full_duplex(fdx), .rx_activity(rx_act), .collision_det(coll),
        .rx_valid_data(rx_vld), .rx_idle(rx_idle), .link_signal_lost(lost),
        .resolver_cross(res_x), .resolver_done(res_done), .rx_polarity_correct(pol_ok),
        .jabber_check_en(jab_en), .col(col), .crs(crs), .link_pass(link_pass),
        .crossover_done(x_done), .pair_cross(pair_x), .tx_pair_oe_n(tp_oe_n),
        .tx100_power_down(pd100)
    );
    tbx_sta_model i_sta (
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in),
        .rd_data(rd_data), .rd_done(rd_done)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
        cmp_count++;
        if (seen !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // read result is noted first and judged when the model hands it back
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
        exp_q.push_back(e);
        i_sta.frame(`TBX_OP_READ, pa, ra, 16'h0000);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        i_sta.frame(`TBX_OP_WRITE, phy_addr, ra, d);
    endtask
    task automatic txp(output int n);
        n = 0;
        @(posedge clk);
        tx_en <= 1'b1;
        tick(5);
        chk("crs", 16'(crs), 16'h0001);
        tx_en <= 1'b0;
        repeat (SQE + 8) begin
            @(posedge clk);
            n += int'(col === 1'b1);
        end
    endtask
    always @(posedge rd_done) begin
        chk("read data", rd_data, exp_q.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h3b6b62e5));
        rst = 1'b1;
        {tx_en, xpin, pol_det, jab_det, fault, spd10, fdx, rx_act} = 8'h00;
        {coll, rx_vld, rx_idle, lost, res_x, res_done} = 6'h00;
        phy_addr = 5'($urandom);
        tick(5);
        rst <= 1'b0;
        tick(3);
        chk("jabber_check_en", 16'(jab_en), 16'h0001);
        rd(phy_addr, `TBX_REG_TEN_OPS, `TBX_OPS_RESET);
        rd(phy_addr, `TBX_REG_EXT_CTL, 16'h4000 | `TBX_EXT_RESET);
        for (int n = 0; n < 6; n++) begin
            r = $urandom;
            @(posedge clk);
            {spd10, fault, xpin, res_x, res_done} <= r[4:0];
            // reserved bits keep defaults; read-only bits 15 and 14 of v19 written against their value
            v18 = (r[15:0] & 16'h002f) | 16'h0010;
            v19 = (r[31:16] & 16'h0381) | 16'ha000;
            wr(`TBX_REG_TEN_OPS, v18);
            wr(`TBX_REG_EXT_CTL, v19);
            rd(phy_addr, `TBX_REG_TEN_OPS, v18);
            rd(phy_addr, `TBX_REG_EXT_CTL, (v19 & 16'h0381) | 16'h4000 | 16'(fault) << 13);
            chk("jabber_check_en", 16'(jab_en), 16'(!v18[5]));
            if (v18[1]) chk("link_pass", 16'(link_pass), 16'h0001);
            chk("tx_pair_oe_n", 16'(tp_oe_n), 16'(v19[7]));
            chk("tx100_power_down", 16'(pd100), 16'(v19[0] & spd10));
            chk("pair_cross", 16'(pair_x), 16'(v19[9] ? xpin & res_x : v19[8]));
            chk("crossover_done", 16'(x_done), 16'(v19[9] & xpin & res_done));
        end
        wr(`TBX_REG_TEN_OPS, 16'h0010);
        @(posedge clk);
        {pol_det, jab_det, rx_act} <= 3'h7;
        tick(4);
        chk("rx_polarity_correct", 16'(pol_ok), 16'h0001);
        chk("crs", 16'(crs), 16'h0001);
        rd(phy_addr, `TBX_REG_TEN_OPS, 16'hc010);
        @(posedge clk);
        {jab_det, rx_act} <= 2'h0;
        // jabber seen after the last snapshot is still reported once
        rd(phy_addr, `TBX_REG_TEN_OPS, 16'hc010);
        rd(phy_addr, `TBX_REG_TEN_OPS, 16'h4010);
        wr(`TBX_REG_TEN_OPS, 16'h0018);
        chk("rx_polarity_correct", 16'(pol_ok), 16'h0000);
        @(posedge clk);
        {pol_det, spd10, fdx, lost} <= 4'h5;
        wr(`TBX_REG_TEN_OPS, 16'h0010);
        chk("link_pass", 16'(link_pass), 16'h0000);
        lost <= 1'b0;
        rx_vld <= 1'b1;
        tick(2);
        rx_vld <= 1'b0;
        tick(4);
        chk("link_pass", 16'(link_pass), 16'h0001);
        wr(`TBX_REG_TEN_OPS, 16'h0011);
        @(posedge clk);
        lost <= 1'b1;
        @(posedge clk);
        {lost, rx_vld} <= 2'h1;
        tick(4);
        chk("link_pass", 16'(link_pass), 16'h0000);
        {rx_vld, rx_idle} <= 2'h1;
        tick(4);
        chk("link_pass", 16'(link_pass), 16'h0001);
        rx_idle <= 1'b0;
        wr(`TBX_REG_TEN_OPS, 16'h0010);
        txp(hi);
        chk("sqe width", 16'(hi), 16'(SQE));
        fdx <= 1'b1;
        txp(hi);
        chk("sqe in full duplex", 16'(hi), 16'h0000);
        // reversal seen since the last read is still latched
        rd(phy_addr, `TBX_REG_TEN_OPS, 16'h4010);
        fdx <= 1'b0;
        wr(`TBX_REG_TEN_OPS, 16'h0014);
        txp(hi);
        chk("sqe inhibited", 16'(hi), 16'h0000);
        coll <= 1'b1;
        tick(2);
        chk("col", 16'(col), 16'h0001);
        coll <= 1'b0;
        i_sta.hp = 100.0;
        rd(phy_addr, `TBX_REG_TEN_OPS, 16'h0014);
        i_sta.hp = 32.0;
        rd(phy_addr ^ 5'h01, `TBX_REG_TEN_OPS, 16'hffff);
        rd(phy_addr, 5'h11, 16'hffff);
        tick(10);
        summarize();
    end
endmodule
`default_nettype wire
